/* File: verilog/gpio_config_bank.sv */
// Purpose: Twelve-pin configuration bank behind an AXI4-Lite slave
// Assumes: Single clock, pins synchronous to it
// Notes:   Rules of the block listed below
// Function
// R1: Pins 0-3 are configured by the register at byte 18h.
// R2: Pins 4-11 are configured by the register at byte 1Ch.
// R3: A cleared function select bit makes the pin general purpose.
// R4: A set driver type bit gives push/pull, a cleared one open-drain.
// R5: A set direction bit makes the pin an output, cleared an input.
// R6: Output pins drive the written level; reads return the pin level.
// R7: Pins map to ascending bits from the lowest bit of each field.
// R8: Only a pin set as input may raise wake or interrupt events.
// R9: Wake also needs the pin's wake enable bit.
// R10: Defaults come from EEPROM, else programmed OTP, else fixed.
// R11: The fixed function select default is all ones.
// R12: The fixed driver, direction and level defaults are zero.
// R13: USB or lite reset restores the last loaded image.
// R14: Reset protection stops those resets from restoring fields.
// R15: The level bit of an input pin has no defined reset state.
// R16: Bits 31:16 of the low register read zero and ignore writes.
//
// Our own choice: register access over AXI4-Lite.
`include "gpio_config_bank_defines.svh"

module gpio_config_bank (
	input  wire logic                         core_clk_i,
	input  wire logic                         nrst_i,
	input  wire logic [7:0]                   awaddr_i,
	input  wire logic                         awvalid_i,
	output logic                              awready_o,
	input  wire logic [31:0]                  wdata_i,
	input  wire logic [3:0]                   wstrb_i,
	input  wire logic                         wvalid_i,
	output logic                              wready_o,
	output logic [1:0]                        bresp_o,
	output logic                              bvalid_o,
	input  wire logic                         bready_i,
	input  wire logic [7:0]                   araddr_i,
	input  wire logic                         arvalid_i,
	output logic                              arready_o,
	output logic [31:0]                       rdata_o,
	output logic [1:0]                        rresp_o,
	output logic                              rvalid_o,
	input  wire logic                         rready_i,
	input  wire logic                         usb_reset_i,
	input  wire logic                         image_load_i,
	input  wire logic                         eeprom_present_i,
	input  wire gpio_config_bank_pkg::pin_cfg_t eeprom_image_i,
	input  wire logic                         otp_programmed_i,
	input  wire gpio_config_bank_pkg::pin_cfg_t otp_image_i,
	input  wire logic [11:0]                  pin_in_i,
	output logic [11:0]                       pin_out_o,
	output logic [11:0]                       pin_oe_o,
	output logic [11:0]                       pin_function_select_o,
	output logic                              wake_o,
	output logic                              irq_o
);
	import gpio_config_bank_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Address decode, shared by the write and read paths
	function automatic reg_sel_t decode_addr(input logic [7:0] a);
		reg_sel_t s;
		s = SEL_NONE;
		case (a)
			`OFF_CFG_LOW:  s = SEL_CFG_LOW;  // [R1]
			`OFF_CFG_HIGH: s = SEL_CFG_HIGH; // [R2]
			`OFF_IRQ_STAT: s = SEL_IRQ_STAT;
			`OFF_IRQ_MASK: s = SEL_IRQ_MASK;
			`OFF_CTRL:     s = SEL_CTRL;
			default:       s = SEL_NONE;
		endcase
		return s;
	endfunction

	////////////////////////////////////////////////////////////////////
	// State
	pin_cfg_t    cfg;
	pin_cfg_t    image;
	pin_cfg_t    next_cfg;
	logic [11:0] wake_en;
	logic        protect;
	logic        lite_pulse;
	logic [11:0] irq_stat;
	logic [11:0] irq_mask;
	logic        aw_full;
	logic        w_full;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic [11:0] pin_event;
	reg_sel_t    rd_sel_q;

	////////////////////////////////////////////////////////////////////
	// Write path decode
	wire         wr_fire  = aw_full & w_full & ~bvalid_o;
	reg_sel_t    wr_sel;
	assign wr_sel = decode_addr(awaddr_q);
	wire  [31:0] wmask    = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
	                         {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire  [31:0] wbits    = wdata_q & wmask;
	wire         low_hit  = wr_fire & (wr_sel == SEL_CFG_LOW);
	wire         high_hit = wr_fire & (wr_sel == SEL_CFG_HIGH);
	wire         stat_hit = wr_fire & (wr_sel == SEL_IRQ_STAT);
	wire         mask_hit = wr_fire & (wr_sel == SEL_IRQ_MASK);
	wire         ctrl_hit = wr_fire & (wr_sel == SEL_CTRL);
	wire         wr_bad   = wr_fire & (wr_sel == SEL_NONE);

	// Default source: EEPROM, then OTP, then fixed values
	pin_cfg_t fixed_cfg;
	pin_cfg_t load_src;
	assign fixed_cfg = '{pin_function_select: `FIX_FUN, // [R11]
	                     pin_driver_type:     `FIX_ZERO, // [R12]
	                     pin_direction:       `FIX_ZERO,
	                     pin_level_bits:      `FIX_ZERO};
	assign load_src  = eeprom_present_i ? eeprom_image_i   // [R10]
	                 : otp_programmed_i ? otp_image_i
	                 : fixed_cfg;

	// Restore request, suppressed by protection
	wire restore = (usb_reset_i | lite_pulse) & ~protect; // [R13] [R14]

	////////////////////////////////////////////////////////////////////
	// Software write merge into the configuration fields
	always_comb begin
		next_cfg = cfg;
		if (low_hit && wstrb_q[0]) begin
			next_cfg.pin_level_bits[3:0] =
				wdata_q[`LOW_LVL_LSB +: 4]; // [R6] [R7]
			next_cfg.pin_direction[3:0] =
				wdata_q[`LOW_DIR_LSB +: 4]; // [R5]
		end
		if (low_hit && wstrb_q[1]) begin
			next_cfg.pin_driver_type[3:0] =
				wdata_q[`LOW_DRV_LSB +: 4]; // [R4]
			next_cfg.pin_function_select[3:0] =
				wdata_q[`LOW_FUN_LSB +: 4]; // [R3]
		end
		if (high_hit && wstrb_q[0])
			next_cfg.pin_level_bits[11:4] =
				wdata_q[`HIGH_LVL_LSB +: 8]; // [R6] [R7]
		if (high_hit && wstrb_q[1])
			next_cfg.pin_direction[11:4] =
				wdata_q[`HIGH_DIR_LSB +: 8]; // [R5]
		if (high_hit && wstrb_q[2])
			next_cfg.pin_driver_type[11:4] =
				wdata_q[`HIGH_DRV_LSB +: 8]; // [R4]
		if (high_hit && wstrb_q[3])
			next_cfg.pin_function_select[11:4] =
				wdata_q[`HIGH_FUN_LSB +: 8]; // [R3]
	end

	// Configuration and image registers; load, then restore, then write
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg   <= '{`FIX_FUN, `FIX_ZERO, `FIX_ZERO, `FIX_ZERO};
			image <= '{`FIX_FUN, `FIX_ZERO, `FIX_ZERO, `FIX_ZERO};
		end else if (image_load_i) begin
			cfg   <= load_src; // [R10]
			image <= load_src;
		end else if (restore) begin
			cfg   <= image; // [R13]
		end else begin
			cfg   <= next_cfg;
		end
	end

	// Control, mask and lite reset pulse
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wake_en    <= 12'h000;
			protect    <= 1'b0;
			lite_pulse <= 1'b0;
			irq_mask   <= 12'h000;
		end else begin
			lite_pulse <= ctrl_hit & wbits[`CTRL_LITE_BIT];
			if (ctrl_hit && wstrb_q[0])
				wake_en[7:0] <= wdata_q[`CTRL_WAKE_LSB +: 8];
			if (ctrl_hit && wstrb_q[1])
				wake_en[11:8] <= wdata_q[`CTRL_WAKE_LSB + 8 +: 4];
			if (ctrl_hit && wstrb_q[2])
				protect <= wdata_q[`CTRL_PROT_BIT]; // [R14]
			if (mask_hit)
				irq_mask <= (irq_mask & ~wmask[11:0]) | wbits[11:0];
		end
	end

	// Sticky status, set wins over write-one-to-clear
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			irq_stat <= 12'h000;
		else
			irq_stat <= (irq_stat & ~(wbits[11:0] & {12{stat_hit}}))
				| pin_event; // [R8]
	end

	// Interrupt level and function select outputs
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_o                 <= 1'b0;
			pin_function_select_o <= `FIX_FUN;
		end else begin
			irq_o                 <= |(irq_stat & irq_mask);
			pin_function_select_o <= cfg.pin_function_select; // [R3]
		end
	end

	////////////////////////////////////////////////////////////////////
	// Write channels: address and data taken in either order
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aw_full   <= 1'b0;
			w_full    <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			awready_o <= 1'b0;
			wready_o  <= 1'b0;
			bvalid_o  <= 1'b0;
			bresp_o   <= `RESP_OKAY;
		end else begin
			if (awvalid_i && awready_o) begin
				aw_full   <= 1'b1;
				awaddr_q  <= awaddr_i;
				awready_o <= 1'b0;
			end else if (!aw_full && !bvalid_o) begin
				awready_o <= 1'b1;
			end
			if (wvalid_i && wready_o) begin
				w_full   <= 1'b1;
				wdata_q  <= wdata_i;
				wstrb_q  <= wstrb_i;
				wready_o <= 1'b0;
			end else if (!w_full && !bvalid_o) begin
				wready_o <= 1'b1;
			end
			if (wr_fire) begin
				aw_full  <= 1'b0;
				w_full   <= 1'b0;
				bvalid_o <= 1'b1;
				bresp_o  <= wr_bad ? `RESP_SLVERR : `RESP_OKAY;
			end else if (bvalid_o && bready_i) begin
				bvalid_o <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read mux; level bits show the pin itself
	reg_sel_t    rd_sel;
	logic [31:0] rd_word;
	assign rd_sel = decode_addr(araddr_i);
	always_comb begin
		case (rd_sel)
			SEL_CFG_LOW:  rd_word = {16'h0000, // [R16]
				cfg.pin_function_select[3:0], cfg.pin_driver_type[3:0],
				cfg.pin_direction[3:0], pin_in_i[3:0]}; // [R6] [R15]
			SEL_CFG_HIGH: rd_word = {cfg.pin_function_select[11:4],
				cfg.pin_driver_type[11:4], cfg.pin_direction[11:4],
				pin_in_i[11:4]}; // [R2] [R7]
			SEL_IRQ_STAT: rd_word = {20'h00000, irq_stat};
			SEL_IRQ_MASK: rd_word = {20'h00000, irq_mask};
			SEL_CTRL:     rd_word = {15'h0000, protect, 4'h0, wake_en};
			default:      rd_word = 32'h0000_0000;
		endcase
	end

	// Read channel: one read under way at a time
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			arready_o <= 1'b0;
			rvalid_o  <= 1'b0;
			rdata_o   <= 32'h0000_0000;
			rresp_o   <= `RESP_OKAY;
			rd_sel_q  <= SEL_NONE;
		end else if (arvalid_i && arready_o) begin
			arready_o <= 1'b0;
			rvalid_o  <= 1'b1;
			rdata_o   <= rd_word;
			rd_sel_q  <= rd_sel;
			rresp_o   <= (rd_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end else if (rvalid_o && rready_i) begin
			rvalid_o  <= 1'b0;
			arready_o <= 1'b1;
		end else if (!rvalid_o) begin
			arready_o <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin drivers and event detection
	pin_drive_stage u_drive (
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.cfg_i      (cfg),
		.pin_out_o  (pin_out_o),
		.pin_oe_o   (pin_oe_o)
	);

	pin_event_detect u_event (
		.core_clk_i  (core_clk_i),
		.nrst_i      (nrst_i),
		.pin_in_i    (pin_in_i),
		.gpio_mode_i (~cfg.pin_function_select),
		.direction_i (cfg.pin_direction),
		.wake_en_i   (wake_en),
		.event_o     (pin_event),
		.wake_o      (wake_o)
	);

	////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_wr_taken;
		aw_full && w_full && !bvalid_o;
	endsequence
	sequence s_wr_answer;
		bvalid_o ##0 (bresp_o == `RESP_OKAY);
	endsequence

	a_write_answer: assert property (@(posedge core_clk_i) // [R1] [R2]
		disable iff (!nrst_i)
		s_wr_taken ##0 (wr_sel != SEL_NONE) |=> s_wr_answer)
		else $error("write not answered okay");

	a_low_reserved: assert property (@(posedge core_clk_i) // [R16]
		disable iff (!nrst_i)
		rvalid_o && rd_sel_q == SEL_CFG_LOW |-> rdata_o[31:16] == 16'h0000)
		else $error("reserved bits read nonzero");

	a_read_level: assert property (@(posedge core_clk_i) // [R6] [R7]
		disable iff (!nrst_i)
		arvalid_i && arready_o && rd_sel == SEL_CFG_HIGH
		|=> rdata_o[7:0] == $past(pin_in_i[11:4])
		&& rdata_o[31:24] == $past(cfg.pin_function_select[11:4]))
		else $error("high register layout wrong");

	a_restore_image: assert property (@(posedge core_clk_i) // [R13]
		disable iff (!nrst_i)
		usb_reset_i && !protect && !image_load_i |=> cfg == $past(image))
		else $error("image not restored");

	a_protect_hold: assert property (@(posedge core_clk_i) // [R14]
		disable iff (!nrst_i)
		usb_reset_i && protect && !image_load_i && !wr_fire
		|=> $stable(cfg))
		else $error("protected field changed");

	a_eeprom_first: assert property (@(posedge core_clk_i) // [R10]
		disable iff (!nrst_i)
		image_load_i && eeprom_present_i |=> image == $past(eeprom_image_i))
		else $error("eeprom image not taken");
	a_fixed_enable: assert property (@(posedge core_clk_i) // [R11]
		disable iff (!nrst_i)
		image_load_i && !eeprom_present_i && !otp_programmed_i
		|=> cfg.pin_function_select == 12'hFFF)
		else $error("fixed select default wrong");
	a_fixed_zero: assert property (@(posedge core_clk_i) // [R12]
		disable iff (!nrst_i)
		image_load_i && !eeprom_present_i && !otp_programmed_i
		|=> cfg.pin_driver_type == 12'h000 && cfg.pin_direction == 12'h000
		&& cfg.pin_level_bits == 12'h000)
		else $error("fixed zero default wrong");

	a_low_write: assert property (@(posedge core_clk_i) // [R3] [R5]
		disable iff (!nrst_i)
		low_hit && wstrb_q == 4'hF && !image_load_i && !restore
		|=> cfg.pin_function_select[3:0] == $past(wdata_q[15:12])
		&& cfg.pin_direction[3:0] == $past(wdata_q[7:4]))
		else $error("low register write lost");

endmodule

/* File: include/gpio_config_bank_defines.svh */
// Purpose: Offsets, field positions and reset values of the pin bank
// Assumes: Byte addresses on an 8-bit register bus address
// Notes:   Included by bare name from the design files
`ifndef GPIO_CONFIG_BANK_DEFINES_SVH
`define GPIO_CONFIG_BANK_DEFINES_SVH

////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define OFF_CFG_LOW    8'h18
`define OFF_CFG_HIGH   8'h1C
`define OFF_IRQ_STAT   8'h40
`define OFF_IRQ_MASK   8'h44
`define OFF_CTRL       8'h48

////////////////////////////////////////////////////////////////////////
// Field positions, low register (pins 0-3)
`define LOW_LVL_LSB    0
`define LOW_DIR_LSB    4
`define LOW_DRV_LSB    8
`define LOW_FUN_LSB    12
// Field positions, high register (pins 4-11)
`define HIGH_LVL_LSB   0
`define HIGH_DIR_LSB   8
`define HIGH_DRV_LSB   16
`define HIGH_FUN_LSB   24
// Control register fields
`define CTRL_WAKE_LSB  0
`define CTRL_PROT_BIT  16
`define CTRL_LITE_BIT  17

////////////////////////////////////////////////////////////////////////
// Fixed defaults and bus answers
`define FIX_FUN        12'hFFF
`define FIX_ZERO       12'h000
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

/* File: include/gpio_config_bank_pkg.sv */
// Purpose: Types shared by the pin bank design files
// Assumes: Twelve pins
// Notes:   Constants live in the defines header
package gpio_config_bank_pkg;

	// One bit per pin for each configuration field
	typedef struct packed {
		logic [11:0] pin_function_select;
		logic [11:0] pin_driver_type;
		logic [11:0] pin_direction;
		logic [11:0] pin_level_bits;
	} pin_cfg_t;

	// Register selected by a bus address
	typedef enum logic [2:0] {
		SEL_CFG_LOW,
		SEL_CFG_HIGH,
		SEL_IRQ_STAT,
		SEL_IRQ_MASK,
		SEL_CTRL,
		SEL_NONE
	} reg_sel_t;

endpackage

/* File: verilog/pin_drive_stage.sv */
// Purpose: Registered pin drivers from the configuration fields
// Assumes: Output enable high while the pin is driven
// Notes:   Open-drain pins only ever drive low
module pin_drive_stage
	import gpio_config_bank_pkg::*;
(
	input  wire logic                         core_clk_i,
	input  wire logic                         nrst_i,
	input  wire gpio_config_bank_pkg::pin_cfg_t cfg_i,
	output logic [11:0]                       pin_out_o,
	output logic [11:0]                       pin_oe_o
);

	logic [11:0] next_oe;

	// Per pin enable: general purpose, output, push/pull or low level
	generate
		for (genvar i = 0; i < 12; i++) begin : g_pin
			assign next_oe[i] = ~cfg_i.pin_function_select[i] // [R3]
				& cfg_i.pin_direction[i]                  // [R5]
				& (cfg_i.pin_driver_type[i]               // [R4]
				| ~cfg_i.pin_level_bits[i]);
		end
	endgenerate

	// Output registers
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_out_o <= 12'h000;
			pin_oe_o  <= 12'h000;
		end else begin
			pin_out_o <= cfg_i.pin_level_bits; // [R6]
			pin_oe_o  <= next_oe;
		end
	end

	// Input pins never driven
	a_input_no_drive: assert property (@(posedge core_clk_i) // [R5]
		disable iff (!nrst_i)
		1'b1 |=> (pin_oe_o & ~$past(cfg_i.pin_direction)) == 12'h000)
		else $error("input pin driven");

	// Open-drain pin floats for a high level
	a_od_high_float: assert property (@(posedge core_clk_i) // [R4]
		disable iff (!nrst_i)
		1'b1 |=> (pin_oe_o & ~$past(cfg_i.pin_driver_type)
			& $past(cfg_i.pin_level_bits)) == 12'h000)
		else $error("open-drain pin drove high");

endmodule

/* File: verilog/pin_event_detect.sv */
// Purpose: Level change events and wake pulses on input pins
// Assumes: Pin levels synchronous to the clock
// Notes:   First cycle after reset only primes the history
module pin_event_detect (
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	input  wire logic [11:0] pin_in_i,
	input  wire logic [11:0] gpio_mode_i,
	input  wire logic [11:0] direction_i,
	input  wire logic [11:0] wake_en_i,
	output logic [11:0]      event_o,
	output logic             wake_o
);

	logic [11:0] last_level;
	logic        primed;
	wire  [11:0] eligible = gpio_mode_i & ~direction_i; // [R8]
	wire  [11:0] change   = (pin_in_i ^ last_level) & {12{primed}};
	wire  [11:0] next_ev  = change & eligible;

	// History and event registers
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			last_level <= 12'h000;
			primed     <= 1'b0;
			event_o    <= 12'h000;
			wake_o     <= 1'b0;
		end else begin
			last_level <= pin_in_i;
			primed     <= 1'b1;
			event_o    <= next_ev;
			wake_o     <= |(next_ev & wake_en_i); // [R9]
		end
	end

	// Wake only from an enabled input pin
	a_wake_input: assert property (@(posedge core_clk_i) // [R8] [R9]
		disable iff (!nrst_i)
		wake_o |-> ($past(wake_en_i & ~direction_i) != 12'h000))
		else $error("wake from non-input pin");

	// Events only on input pins
	a_event_input: assert property (@(posedge core_clk_i) // [R8]
		disable iff (!nrst_i)
		1'b1 |=> (event_o & $past(direction_i)) == 12'h000)
		else $error("event on output pin");

endmodule

/* File: tb/pin_board_model.sv */
// Purpose: Board side of the twelve pins, pull-ups plus external drivers
// Assumes: Device output enable high while the device drives a pin
// Notes:   A pin released by device and board floats to its pull-up level, never holds its value
module pin_board_model (
	input  wire logic [11:0] dev_out_i,
	input  wire logic [11:0] dev_oe_i,
	input  wire logic [11:0] ext_en_i,
	input  wire logic [11:0] ext_val_i,
	output logic [11:0]      pin_level_o
);
	timeunit 1ns;
	timeprecision 1ns;

	////////////////////////////////////////////////////////////////////
	// Wire level: device first, then board driver, else pull-up
	// Released open-drain pin reads high unless the board driver is enabled on it
	assign pin_level_o = (dev_oe_i & dev_out_i) | (~dev_oe_i & ext_en_i
		& ext_val_i) | (~dev_oe_i & ~ext_en_i);
endmodule

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench of the pin configuration bank
// Assumes: AXI4-Lite master tasks, board model on the pins
// Notes:   Expected words are built from the field layout by hand
`include "gpio_config_bank_defines.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import gpio_config_bank_pkg::*;

	logic        core_clk_i;
	logic        nrst_i;
	logic [7:0]  awaddr;
	logic [7:0]  araddr;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        awvalid;
	logic        wvalid;
	logic        bready;
	logic        arvalid;
	logic        rready;
	logic        awready;
	logic        wready;
	logic        bvalid;
	logic        arready;
	logic        rvalid;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic [31:0] rdata;
	logic        usb_reset;
	logic        image_load;
	logic        eeprom_present;
	logic        otp_programmed;
	pin_cfg_t    eeprom_image;
	pin_cfg_t    otp_image;
	logic [11:0] pin_level;
	logic [11:0] pin_out;
	logic [11:0] pin_oe;
	logic [11:0] fsel;
	logic [11:0] ext_en;
	logic [11:0] ext_val;
	logic        wake;
	logic        irq;
	int          num_errors;
	int          n_checks;
	int          cycles;
	int          wake_cnt;
	int          wake_base;

	////////////////////////////////////////////////////////////////////
	// Design and board
	gpio_config_bank i_dut (
		.core_clk_i(core_clk_i), .nrst_i(nrst_i), .awaddr_i(awaddr),
		.awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata),
		.wstrb_i(wstrb), .wvalid_i(wvalid), .wready_o(wready),
		.bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
		.araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready),
		.rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid),
		.rready_i(rready), .usb_reset_i(usb_reset),
		.image_load_i(image_load), .eeprom_present_i(eeprom_present),
		.eeprom_image_i(eeprom_image), .otp_programmed_i(otp_programmed),
		.otp_image_i(otp_image), .pin_in_i(pin_level),
		.pin_out_o(pin_out), .pin_oe_o(pin_oe),
		.pin_function_select_o(fsel), .wake_o(wake), .irq_o(irq)
	);
	pin_board_model i_board (
		.dev_out_i(pin_out), .dev_oe_i(pin_oe), .ext_en_i(ext_en),
		.ext_val_i(ext_val), .pin_level_o(pin_level)
	);

	////////////////////////////////////////////////////////////////////
	// Clock, hang guard and wake pulse counter
	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cycles++;
		if (wake === 1'b1) wake_cnt++;
		if (cycles == 5000) begin
			num_errors++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	// Write: address and data offered together, each dropped when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge core_clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge core_clk_i);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		check("bresp", 32'(er), 32'(bresp));
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge core_clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge core_clk_i);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rready <= 1'b0;
		check("rresp", 32'(er), 32'(rresp));
		check("rdata", ed, rdata);
	endtask
	task automatic pulse_usb;
		@(posedge core_clk_i);
		usb_reset <= 1'b1;
		@(posedge core_clk_i);
		usb_reset <= 1'b0;
		tick(3);
	endtask
	task automatic pulse_load;
		@(posedge core_clk_i);
		image_load <= 1'b1;
		@(posedge core_clk_i);
		image_load <= 1'b0;
		tick(3);
	endtask

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{nrst_i, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, usb_reset, image_load} = '0;
		wstrb = 4'hF;
		{eeprom_present, otp_programmed, eeprom_image, otp_image} = '0;
		{ext_en, ext_val, num_errors, n_checks, cycles, wake_cnt} = '0;
		tick(4);
		nrst_i <= 1'b1;
		tick(2);
		axi_rd(`OFF_CFG_LOW, 32'h0000F00F, `RESP_OKAY); // Low
		axi_rd(`OFF_CFG_HIGH, 32'hFF0000FF, `RESP_OKAY); // High
		axi_rd(`OFF_IRQ_STAT, 32'h0, `RESP_OKAY);
		axi_rd(`OFF_IRQ_MASK, 32'h0, `RESP_OKAY);
		$display("test reset defaults done");
		axi_wr(`OFF_CFG_LOW, 32'hFFFF0F35, `RESP_OKAY); // Reserved
		axi_rd(`OFF_CFG_LOW, 32'h00000F3D, `RESP_OKAY); // Level
		axi_wr(`OFF_CFG_HIGH, 32'h00000F05, `RESP_OKAY); // Open-drain
		axi_rd(`OFF_CFG_HIGH, 32'h00000FF5, `RESP_OKAY); // Bit order
		check("pin_oe", 32'h0A3, 32'(pin_oe)); // Drivers
		check("pin_level", 32'hF5D, 32'(pin_level)); // Driven level
		check("fsel", 32'h000, 32'(fsel)); // General purpose
		check("pin_out", 32'h055, 32'(pin_out)); // Written level
		$display("test pin config done");
		axi_wr(8'h30, 32'hFFFFFFFF, `RESP_SLVERR);
		axi_rd(8'h30, 32'h0, `RESP_SLVERR);
		$display("test unmapped done");
		axi_wr(`OFF_IRQ_STAT, 32'h00000FFF, `RESP_OKAY);
		axi_rd(`OFF_IRQ_STAT, 32'h0, `RESP_OKAY);
		axi_wr(`OFF_IRQ_MASK, 32'h8, `RESP_OKAY);
		@(posedge core_clk_i);
		ext_en <= 12'h008;
		tick(4);
		check("irq", 32'h1, 32'(irq)); // Input pin event
		axi_wr(`OFF_CFG_LOW, 32'h00000F37, `RESP_OKAY); // Output pin
		tick(4);
		axi_rd(`OFF_IRQ_STAT, 32'h8, `RESP_OKAY); // Inputs only
		axi_wr(`OFF_IRQ_MASK, 32'h0, `RESP_OKAY);
		tick(2);
		check("irq masked", 32'h0, 32'(irq));
		axi_wr(`OFF_IRQ_MASK, 32'h8, `RESP_OKAY);
		tick(2);
		check("irq unmasked", 32'h1, 32'(irq));
		axi_wr(`OFF_IRQ_STAT, 32'h8, `RESP_OKAY);
		tick(2);
		check("irq cleared", 32'h0, 32'(irq));
		axi_rd(`OFF_IRQ_STAT, 32'h0, `RESP_OKAY);
		$display("test interrupt done");
		axi_wr(`OFF_CTRL, 32'h4, `RESP_OKAY);
		wake_base = wake_cnt;
		@(posedge core_clk_i);
		ext_en <= 12'h00C;
		tick(4);
		ext_val <= 12'h008;
		tick(4);
		check("wake count", 32'h1, 32'(wake_cnt - wake_base));
		ext_en <= 12'h000;
		$display("test wake done");
		axi_wr(`OFF_CTRL, 32'h00010000, `RESP_OKAY);
		pulse_usb();
		axi_rd(`OFF_CFG_LOW, 32'h00000F3F, `RESP_OKAY); // Protected
		axi_wr(`OFF_CTRL, 32'h0, `RESP_OKAY);
		pulse_usb();
		axi_rd(`OFF_CFG_LOW, 32'h0000F00F, `RESP_OKAY); // USB restore
		axi_wr(`OFF_CFG_LOW, 32'h00000F35, `RESP_OKAY);
		axi_wr(`OFF_CTRL, 32'h00020000, `RESP_OKAY);
		tick(3);
		axi_rd(`OFF_CFG_LOW, 32'h0000F00F, `RESP_OKAY); // Lite restore
		$display("test restore done");
		@(posedge core_clk_i);
		eeprom_present <= 1'b1;
		otp_programmed <= 1'b1;
		eeprom_image <= {12'hA5C, 12'h3C1, 24'h0};
		otp_image <= {12'h3C3, 36'h0};
		pulse_load();
		check("fsel eeprom", 32'hA5C, 32'(fsel)); // EEPROM first
		axi_rd(`OFF_CFG_LOW, 32'h0000C10F, `RESP_OKAY); // Image
		axi_wr(`OFF_CFG_LOW, 32'h0, `RESP_OKAY);
		pulse_usb();
		axi_rd(`OFF_CFG_LOW, 32'h0000C10F, `RESP_OKAY); // Last image
		eeprom_present <= 1'b0;
		pulse_load();
		check("fsel otp", 32'h3C3, 32'(fsel)); // OTP second
		otp_programmed <= 1'b0;
		pulse_load();
		check("fsel fixed", 32'hFFF, 32'(fsel)); // Fixed
		wstrb <= 4'h8;
		axi_wr(`OFF_CFG_HIGH, 32'h0FFFFF00, `RESP_OKAY); // Top byte
		axi_rd(`OFF_CFG_HIGH, 32'h0F0000FF, `RESP_OKAY); // Strobed
		wstrb <= 4'hF;
		$display("test image load done");
		conclude();
	end
endmodule
